// ==== src/pmsr_map.svh ====
`ifndef PMSR_MAP_SVH
`define PMSR_MAP_SVH
`define PMSR_I2C_ADDR   7'h5B
`define PMSR_ID_VAL     8'hA5 // Arbitrary identity value
`define PMSR_PIN_IDLE   6'h07
`define PMSR_OFS_ID     8'h01
`define PMSR_OFS_TMG    8'h02
`define PMSR_OFS_CFG    8'h03
`define PMSR_OFS_SYS    8'h04
`define PMSR_OFS_B1     8'h05
`define PMSR_OFS_B2     8'h06
`define PMSR_TMG_RST    8'h54
`define PMSR_CFG_RST    8'hC0
`define PMSR_TMG_WMASK  8'hF7
`define PMSR_CLK_MHZ    20
`define PMSR_TICK_US    1000
`define PMSR_LP_STEP_MS 14'h07D0
`define PMSR_IRQ_STEP_MS 14'h00FA
`define PMSR_RST_BASE_MS 8'h01
`endif

// ==== src/pmsr_pkg.sv ====
package pmsr_pkg;
   // Raw per-rail analogue indications
   typedef struct packed {
      logic oc_end;
      logic neg_lim;
      logic zc_trip;
      logic zc_en;
      logic softstart_done;
      logic power_good;
      logic rail_enabled;
   } pmsr_rail_t;

   // Latched per-rail flags
   typedef struct packed {
      logic fault_flag;
      logic hiccup_flag;
      logic neg_limit_flag;
      logic zero_cross_flag;
   } pmsr_rflag_t;

   // I2C target states
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_ADDR = 7'b0000010,
      ST_ACKA = 7'b0000100,
      ST_WR   = 7'b0001000,
      ST_ACKW = 7'b0010000,
      ST_RD   = 7'b0100000,
      ST_ACKR = 7'b1000000
   } pmsr_st_t;
endpackage : pmsr_pkg

// ==== src/pmsr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmsr_map.svh"
module pmsr_top
   import pmsr_pkg::*;
#(
   parameter int TICK_CYC = `PMSR_CLK_MHZ * `PMSR_TICK_US
) (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output var  logic       sda_o,
   output var  logic       sda_oe_o,
   input  wire logic       start_button_n_i,
   input  wire logic       high_perf_pin_i,
   input  wire logic       thermal_off_i,
   input  wire logic       thermal_warn_i,
   input  wire pmsr_rail_t rail1_i,
   input  wire pmsr_rail_t rail2_i,
   input  wire logic       startup_done_i,
   input  wire logic       auto_restart_i,
   input  wire logic       rail1_pfm_i,
   output var  logic       irq_out_n_o,
   output var  logic       reset_out_n_o,
   output var  logic       start_out_n_o,
   output var  logic       long_press_o,
   output var  logic       perf_req_o,
   output var  logic [1:0] freq_shift_o,
   output var  logic       rail1_hyst_o
);

   // Two-stage synchronisers for the bus, button, mode and thermal pins and the rail indications
   logic [5:0]  pin_m_q, pin_s_q;
   pmsr_rail_t  r1_m_q, r1_s_q, r2_m_q, r2_s_q;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_m_q <= `PMSR_PIN_IDLE; // Bus idle high, button released
         pin_s_q <= `PMSR_PIN_IDLE;
         r1_m_q  <= '0;
         r1_s_q  <= '0;
         r2_m_q  <= '0;
         r2_s_q  <= '0;
      end else begin
         pin_m_q <= {thermal_warn_i, thermal_off_i, high_perf_pin_i,
                     start_button_n_i, sda_i, scl_i};
         pin_s_q <= pin_m_q;
         r1_m_q  <= rail1_i;
         r1_s_q  <= r1_m_q;
         r2_m_q  <= rail2_i;
         r2_s_q  <= r2_m_q;
      end
   end

   logic scl_s, sda_s, btn_n_s, hpm_s, toff_s, twarn_s;
   assign scl_s   = pin_s_q[0];
   assign sda_s   = pin_s_q[1];
   assign btn_n_s = pin_s_q[2];
   assign hpm_s   = pin_s_q[3];
   assign toff_s  = pin_s_q[4];
   assign twarn_s = pin_s_q[5];

   // Previous bus levels for edge and condition detection
   logic scl_p_q, sda_p_q;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // Millisecond tick divider
   logic [14:0] div_q;
   logic        tick_q;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == 15'(TICK_CYC - 1)) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 15'h0001;
         tick_q <= 1'b0;
      end
   end

   // Software registers
   logic [7:0]  tmg_q, cfg_q;
   logic        toff_flag_q, twarn_flag_q, btn_flag_q;
   pmsr_rflag_t b1_q, b2_q;

   // Buck status byte: latched flags, reserved zero, live bits
   function automatic logic [7:0] buck_byte(input pmsr_rflag_t f,
                                            input pmsr_rail_t  r);
      buck_byte = {f, 1'b0, r.softstart_done, r.power_good,
                   r.rail_enabled};
   endfunction : buck_byte

   // Register read mux, unmapped offsets read zero
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      unique case (a)
         `PMSR_OFS_ID:  reg_read = `PMSR_ID_VAL;
         `PMSR_OFS_TMG: reg_read = tmg_q;
         `PMSR_OFS_CFG: reg_read = cfg_q;
         `PMSR_OFS_SYS: reg_read = {toff_flag_q, twarn_flag_q, btn_flag_q, 5'h00};
         `PMSR_OFS_B1:  reg_read = buck_byte(b1_q, r1_s_q);
         `PMSR_OFS_B2:  reg_read = buck_byte(b2_q, r2_s_q);
         default:       reg_read = 8'h00;
      endcase
   endfunction : reg_read

   // Latched buck flags: set wins, read clears only once cause gone
   function automatic pmsr_rflag_t buck_next(input pmsr_rflag_t f,
                                             input pmsr_rail_t  r,
                                             input logic        rd);
      logic lost, hic, fl, nl, zc;
      lost = r.rail_enabled & r.softstart_done & ~r.power_good;
      hic  = r.oc_end & ~r.power_good;
      fl   = hic | f.hiccup_flag | lost;
      nl   = r.neg_lim;
      zc   = r.zc_trip & r.zc_en;
      buck_next.hiccup_flag     = hic | (f.hiccup_flag & ~rd);
      buck_next.fault_flag      = fl | (f.fault_flag & ~rd);
      buck_next.neg_limit_flag  = nl | (f.neg_limit_flag & ~rd);
      buck_next.zero_cross_flag = zc | (f.zero_cross_flag & ~rd);
   endfunction : buck_next

   // I2C target state and datapath
   pmsr_st_t   st_q;
   logic [3:0] cnt_q;
   logic [7:0] sr_q, tx_q, ptr_q;
   logic       first_q, nack_q, rw_q;
   logic       wr_stb, rd_stb;
   logic [7:0] rd_adr, rd_byte;

   // Write strobe on the data byte's last fall, read strobe on load
   always_comb begin
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      rd_adr = ptr_q;
      rd_byte = reg_read(ptr_q);
      if (!bus_start && !bus_stop && scl_fall) begin
         if (st_q == ST_WR && cnt_q == 4'h8 && !first_q)
            wr_stb = 1'b1;
         if ((st_q == ST_ACKA && rw_q) || (st_q == ST_ACKR && !nack_q))
            rd_stb = 1'b1;
      end
   end

   // Target sequencing: address, pointer, write data, read data
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q     <= ST_IDLE;
         cnt_q    <= '0;
         sr_q     <= '0;
         tx_q     <= '0;
         ptr_q    <= '0;
         first_q  <= 1'b0;
         nack_q   <= 1'b0;
         rw_q     <= 1'b0;
         sda_oe_o <= 1'b0;
         sda_o    <= 1'b0;
      end else if (bus_stop) begin
         st_q     <= ST_IDLE;
         sda_oe_o <= 1'b0;
      end else if (bus_start) begin
         st_q     <= ST_ADDR;
         cnt_q    <= '0;
         sda_oe_o <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: sda_oe_o <= 1'b0;
            ST_ADDR, ST_WR: begin
               if (scl_rise) begin
                  sr_q  <= {sr_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == 4'h8) begin
                  if (st_q == ST_WR) begin
                     st_q     <= ST_ACKW;
                     sda_oe_o <= 1'b1;
                     if (first_q)
                        ptr_q <= sr_q;
                     else
                        ptr_q <= ptr_q + 8'h01;
                     first_q  <= 1'b0;
                  end else if (sr_q[7:1] == `PMSR_I2C_ADDR) begin
                     st_q     <= ST_ACKA;
                     rw_q     <= sr_q[0];
                     sda_oe_o <= 1'b1;
                  end else begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            ST_ACKA, ST_ACKW: begin
               if (scl_fall) begin
                  cnt_q <= '0;
                  if (rd_stb) begin
                     st_q     <= ST_RD;
                     tx_q     <= rd_byte;
                     ptr_q    <= ptr_q + 8'h01;
                     sda_oe_o <= ~rd_byte[7];
                  end else begin
                     st_q     <= ST_WR;
                     first_q  <= (st_q == ST_ACKA);
                     sda_oe_o <= 1'b0;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (cnt_q == 4'h7) begin
                     st_q     <= ST_ACKR;
                     sda_oe_o <= 1'b0;
                  end else begin
                     tx_q     <= {tx_q[6:0], 1'b0};
                     sda_oe_o <= ~tx_q[6];
                     cnt_q    <= cnt_q + 4'h1;
                  end
               end
            end
            ST_ACKR: begin
               if (scl_rise)
                  nack_q <= sda_s;
               else if (scl_fall) begin
                  cnt_q <= '0;
                  if (rd_stb) begin
                     st_q     <= ST_RD;
                     tx_q     <= rd_byte;
                     ptr_q    <= ptr_q + 8'h01;
                     sda_oe_o <= ~rd_byte[7];
                  end else begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Writable registers; reserved timing bit held at zero
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tmg_q <= `PMSR_TMG_RST;
         cfg_q <= `PMSR_CFG_RST;
      end else if (wr_stb) begin
         if (ptr_q == `PMSR_OFS_TMG)
            tmg_q <= sr_q & `PMSR_TMG_WMASK;
         if (ptr_q == `PMSR_OFS_CFG)
            cfg_q <= sr_q;
      end
   end

   logic rd_sys, rd_b1, rd_b2;
   assign rd_sys = rd_stb && rd_adr == `PMSR_OFS_SYS;
   assign rd_b1  = rd_stb && rd_adr == `PMSR_OFS_B1;
   assign rd_b2  = rd_stb && rd_adr == `PMSR_OFS_B2;

   // Thermal flags: live cause keeps them set through a read
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         toff_flag_q  <= 1'b0;
         twarn_flag_q <= 1'b0;
      end else begin
         toff_flag_q  <= toff_s | (toff_flag_q & ~rd_sys);
         twarn_flag_q <= twarn_s | (twarn_flag_q & ~rd_sys);
      end
   end

   // Buck flag latches
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         b1_q <= '0;
         b2_q <= '0;
      end else begin
         b1_q <= buck_next(b1_q, r1_s_q, rd_b1);
         b2_q <= buck_next(b2_q, r2_s_q, rd_b2);
      end
   end

   // Push-button press timer in milliseconds
   logic [13:0] pb_ms_q, irq_ms, lp_ms;
   assign irq_ms = `PMSR_IRQ_STEP_MS * (14'(tmg_q[5:4]) + 14'h0001);
   assign lp_ms  = `PMSR_LP_STEP_MS * (14'(tmg_q[7:6]) + 14'h0001);
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         pb_ms_q <= '0;
      else if (btn_n_s || rd_sys)
         pb_ms_q <= '0;
      else if (tick_q && pb_ms_q != 14'h3FFF)
         pb_ms_q <= pb_ms_q + 14'h0001;
   end

   // Button flag and long-press pulse
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         btn_flag_q   <= 1'b0;
         long_press_o <= 1'b0;
      end else begin
         if (!btn_n_s && tick_q && pb_ms_q + 14'h0001 == irq_ms)
            btn_flag_q <= 1'b1;
         else if (rd_sys)
            btn_flag_q <= 1'b0;
         long_press_o <= !btn_n_s && tick_q && pb_ms_q + 14'h0001 == lp_ms;
      end
   end

   // Reset release delay after start-up completes
   logic [7:0] rst_ms_q, rst_lim;
   assign rst_lim = `PMSR_RST_BASE_MS << tmg_q[2:0];
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_ms_q      <= '0;
         reset_out_n_o <= 1'b0;
      end else if (!startup_done_i) begin
         rst_ms_q      <= '0;
         reset_out_n_o <= 1'b0;
      end else if (rst_ms_q >= rst_lim) begin
         reset_out_n_o <= 1'b1;
      end else if (tick_q) begin
         rst_ms_q <= rst_ms_q + 8'h01;
      end
   end

   // Wake pulse before an automatic restart, lasts until next tick
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         start_out_n_o <= 1'b1;
      else if (auto_restart_i && !cfg_q[4])
         start_out_n_o <= 1'b0;
      else if (tick_q)
         start_out_n_o <= 1'b1;
   end

   // Interrupt pin and configuration outputs
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_out_n_o  <= 1'b1;
         perf_req_o   <= 1'b0;
         freq_shift_o <= 2'h0;
         rail1_hyst_o <= 1'b0;
      end else begin
         irq_out_n_o  <= ~((toff_flag_q & ~cfg_q[7])
                         | (twarn_flag_q & ~cfg_q[6])
                         | btn_flag_q);
         perf_req_o   <= hpm_s & cfg_q[5];
         freq_shift_o <= cfg_q[3:2];
         rail1_hyst_o <= cfg_q[1] & rail1_pfm_i;
      end
   end

endmodule : pmsr_top
`default_nettype wire

// ==== bench/pmsr_top_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmsr_top_props #(
   parameter int TICK_CYC = 20
) (
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic       high_perf_pin_i,
   input wire logic       startup_done_i,
   input wire logic       auto_restart_i,
   input wire logic       rail1_pfm_i,
   input wire logic       irq_out_n_o,
   input wire logic       reset_out_n_o,
   input wire logic       start_out_n_o,
   input wire logic       long_press_o,
   input wire logic       perf_req_o,
   input wire logic [1:0] freq_shift_o,
   input wire logic       rail1_hyst_o
);
   int unsigned rel_q;
   int unsigned wake_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Cycles since start-up completed, saturating
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) rel_q <= 32'h0;
      else if (!startup_done_i) rel_q <= 32'h0;
      else if (rel_q < 32'h0010_0000) rel_q <= rel_q + 32'h1;
   end
   // Length of the current wake pulse
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) wake_q <= 32'h0;
      else wake_q <= start_out_n_o ? 32'h0 : wake_q + 32'h1;
   end

   property p_rst_vals;
      $rose(rstn_i) |-> irq_out_n_o && !reset_out_n_o && start_out_n_o && freq_shift_o == 2'h0;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset values");
   property p_perf_gate;
      !high_perf_pin_i [*6] |=> !perf_req_o;
   endproperty
   a_perf_gate: assert property (p_perf_gate) else $error("perf request without pin");
   property p_rst_cause;
      $rose(reset_out_n_o) |-> $past(startup_done_i);
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("reset released early");
   property p_rst_min;
      $rose(reset_out_n_o) |-> rel_q >= TICK_CYC;
   endproperty
   a_rst_min: assert property (p_rst_min) else $error("reset delay too short");
   property p_wake_cause;
      $fell(start_out_n_o) |-> $past(auto_restart_i);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake pulse without restart");
   property p_wake_len;
      wake_q <= TICK_CYC + 1;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake pulse too long");
   property p_hyst;
      rail1_hyst_o |-> $past(rail1_pfm_i);
   endproperty
   a_hyst: assert property (p_hyst) else $error("hysteretic mode outside pfm");
   property p_lp_pulse;
      long_press_o |=> !long_press_o;
   endproperty
   a_lp_pulse: assert property (p_lp_pulse) else $error("long press not a pulse");
   c_wake: cover property ($fell(start_out_n_o));
   c_rel: cover property ($rose(reset_out_n_o));
   c_irq: cover property ($fell(irq_out_n_o));
endmodule : pmsr_top_props

bind pmsr_top pmsr_top_props #(.TICK_CYC(TICK_CYC)) i_props (
   .clk_i(clk_i), .rstn_i(rstn_i), .high_perf_pin_i(high_perf_pin_i),
   .startup_done_i(startup_done_i), .auto_restart_i(auto_restart_i),
   .rail1_pfm_i(rail1_pfm_i), .irq_out_n_o(irq_out_n_o), .reset_out_n_o(reset_out_n_o),
   .start_out_n_o(start_out_n_o), .long_press_o(long_press_o), .perf_req_o(perf_req_o),
   .freq_shift_o(freq_shift_o), .rail1_hyst_o(rail1_hyst_o)
);
`default_nettype wire

// ==== bench/pmsr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmsr_map.svh"
module pmsr_host_model (
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_pull_o
);
   localparam time QTR = 100; // Quarter of the 400 ns bus clock period
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // One bit: data changes mid-low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      #QTR sda_pull_o = !b;
      #QTR scl_o = 1'b1;
      #QTR r = sda_i;
      #QTR scl_o = 1'b0;
   endtask : bit_io
   // Start or repeated start: data falls while clock high
   task automatic start_c;
      #QTR sda_pull_o = 1'b0;
      #QTR scl_o = 1'b1;
      #QTR sda_pull_o = 1'b1;
      #QTR scl_o = 1'b0;
   endtask : start_c
   task automatic stop_c;
      #QTR sda_pull_o = 1'b1;
      #QTR scl_o = 1'b1;
      #QTR sda_pull_o = 1'b0;
      #QTR;
   endtask : stop_c
   // Byte MSB first plus the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, input logic last,
                          output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(last, ack);
   endtask : byte_io
   task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, output logic nak);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      start_c();
      byte_io({`PMSR_I2C_ADDR, 1'b0}, 1'b1, rx, a0);
      byte_io(ptr, 1'b1, rx, a1);
      byte_io(dat, 1'b1, rx, a2);
      stop_c();
      nak = a0 | a1 | a2;
   endtask : wr
   // Pointer write, repeated start, one byte read and refused
   task automatic rd(input logic [7:0] ptr, output logic [7:0] dat);
      logic [7:0] rx;
      logic       a;
      start_c();
      byte_io({`PMSR_I2C_ADDR, 1'b0}, 1'b1, rx, a);
      byte_io(ptr, 1'b1, rx, a);
      start_c();
      byte_io({`PMSR_I2C_ADDR, 1'b1}, 1'b1, rx, a);
      byte_io(8'hFF, 1'b1, dat, a);
      stop_c();
   endtask : rd
endmodule : pmsr_host_model
`default_nettype wire

// ==== bench/pmsr_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmsr_top_tb_top
   import pmsr_pkg::*;
;
   localparam int TICK = 20;
   localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'hA5, 8'h54, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};
   logic       clk_i, rstn_i, btn_n, perf_pin, t_off, t_warn, auto_rst, pfm, st_done;
   logic       scl, pull, sda_o, sda_oe, irq_n, rst_n, start_n, lp, perf_req, hyst;
   logic [1:0] fshift;
   pmsr_rail_t rail1, rail2;
   int         failures, checks_done, cyc, n;
   wire logic  sda_w;

   // Open-drain data line with pull-up
   assign sda_w = !pull && (!sda_oe || sda_o);
   pmsr_host_model i_host (.sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull));
   pmsr_top #(.TICK_CYC(TICK)) i_dut (
      .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .start_button_n_i(btn_n), .high_perf_pin_i(perf_pin),
      .thermal_off_i(t_off), .thermal_warn_i(t_warn), .rail1_i(rail1), .rail2_i(rail2),
      .startup_done_i(st_done), .auto_restart_i(auto_rst), .rail1_pfm_i(pfm),
      .irq_out_n_o(irq_n), .reset_out_n_o(rst_n), .start_out_n_o(start_n),
      .long_press_o(lp), .perf_req_o(perf_req), .freq_shift_o(fshift), .rail1_hyst_o(hyst)
   );

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         summarize();
      end
   end

   task automatic summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cyc_w(input int k);
      repeat (k) @(negedge clk_i);
   endtask : cyc_w
   task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] d;
      i_host.rd(ofs, d);
      check($sformatf("reg %h", ofs), d, exp);
   endtask : rchk
   task automatic wreg(input logic [7:0] ofs, input logic [7:0] dat);
      logic nak;
      i_host.wr(ofs, dat, nak);
      check("write ack", {7'h0, nak}, 8'h00);
   endtask : wreg

   initial begin
      rstn_i = 1'b0; btn_n = 1'b1; perf_pin = 1'b1; t_off = 1'b0; t_warn = 1'b0;
      auto_rst = 1'b0; pfm = 1'b1; rail1 = '0; rail2 = '0;
      st_done = 1'b0;
      failures = 0; checks_done = 0; cyc = 0;
      cyc_w(12);
      rstn_i = 1'b1;
      // Reset out held until start-up ends, then 16 ms; pin ignored while disabled
      cyc_w(200);
      check("reset out", rst_n, 8'h00);
      check("perf req", perf_req, 8'h00);
      st_done = 1'b1;
      cyc_w(290);
      check("reset out", rst_n, 8'h00);
      cyc_w(50);
      check("reset out", rst_n, 8'h01);
      for (int i = 0; i < 8; i++) rchk(8'(i), RST_TAB[i]);
      // Identity ignores writes, timing takes shortest press codes
      wreg(8'h01, 8'h00);
      wreg(8'h02, 8'h04);
      rchk(8'h01, 8'hA5);
      rchk(8'h02, 8'h04);
      // Masked thermal events, wake pulse enabled
      t_off = 1'b1; t_warn = 1'b1; cyc_w(10);
      check("irq", irq_n, 8'h01);
      t_off = 1'b0; auto_rst = 1'b1; cyc_w(1); auto_rst = 1'b0;
      check("wake", start_n, 8'h00);
      // Unmask, enable pin, shift, hysteresis, wake disable, user bit
      wreg(8'h03, 8'h3F);
      cyc_w(4);
      check("cfg out", {hyst, perf_req, fshift}, 8'h0F);
      // Pin low and rail out of pfm drop both outputs
      perf_pin = 1'b0;
      pfm = 1'b0;
      cyc_w(8);
      check("cfg off", {hyst, perf_req}, 8'h00);
      check("irq", irq_n, 8'h00);
      auto_rst = 1'b1; cyc_w(1); auto_rst = 1'b0; cyc_w(2);
      check("wake", start_n, 8'h01);
      rchk(8'h03, 8'h3F);
      rchk(8'h04, 8'hC0);
      rchk(8'h04, 8'h40);
      t_warn = 1'b0; cyc_w(4);
      rchk(8'h04, 8'h40);
      rchk(8'h04, 8'h00);
      check("irq", irq_n, 8'h01);
      // Buck events latch, live bits follow
      rail1 = 7'b0111111; rail2 = 7'b1000101; cyc_w(4);
      rail1 = 7'b0000111; rail2 = 7'b0000101; cyc_w(4);
      rchk(8'h05, 8'h37);
      rchk(8'h05, 8'h07);
      rchk(8'h06, 8'hC5);
      rchk(8'h06, 8'h85);
      rail2 = 7'b0000111; cyc_w(4);
      rchk(8'h06, 8'h87);
      rchk(8'h06, 8'h07);
      // Held button: irq after 250 ms, long press after 2 s
      btn_n = 1'b0;
      cyc_w(4500);
      check("irq", irq_n, 8'h01);
      cyc_w(1000);
      check("irq", irq_n, 8'h00);
      n = 0;
      while (lp !== 1'b1 && n < 41000) begin
         @(negedge clk_i);
         n++;
      end
      check("long press", {7'h0, n > 33000 && n < 35500}, 8'h01);
      btn_n = 1'b1; cyc_w(4);
      rchk(8'h04, 8'h20);
      rchk(8'h04, 8'h00);
      check("irq", irq_n, 8'h01);
      // Supply lockout in mid-run clears the user bit
      rstn_i = 1'b0;
      cyc_w(2);
      rstn_i = 1'b1;
      cyc_w(4);
      rchk(8'h03, 8'hC0);
      summarize();
   end
endmodule : pmsr_top_tb_top
`default_nettype wire
